// ### irq_accept_pkg.sv
package irq_accept_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_CTRL      = 8'h00;  // Global enable and threshold
  localparam logic [7:0] OFF_PEND      = 8'h04;  // Request bits, write 0 to clear
  localparam logic [7:0] OFF_LVL_LO    = 8'h08;  // Levels of sources 0..7
  localparam logic [7:0] OFF_LVL_HI    = 8'h0C;  // Levels of sources 8..15
  localparam logic [7:0] OFF_CPU       = 8'h10;  // Interface to the CPU core
  localparam logic [7:0] OFF_STATUS    = 8'h14;  // Entry sequence status
  localparam logic [7:0] OFF_VECT      = 8'h18;  // Captured vector and level
  localparam logic [7:0] OFF_PSW       = 8'h1C;  // Live flag word
  localparam logic [7:0] OFF_STACK     = 8'h20;  // Interrupt and user stack pointers
  localparam logic [7:0] OFF_SAVED     = 8'h24;  // Stacked words

  // Field positions in the control register
  localparam int CTRL_GIE_BIT  = 0;
  localparam int CTRL_THR_LSB  = 4;

  // Flag word bit positions
  localparam int PSW_D_BIT     = 2;
  localparam int PSW_I_BIT     = 6;
  localparam int PSW_U_BIT     = 7;

  // Reset values and the watchdog threshold
  localparam logic [2:0]  THR_RESET    = 3'h0;
  localparam logic [2:0]  THR_WATCHDOG = 3'h7;
  localparam logic [15:0] PSW_RESET    = 16'h0000;

  // Entry sequence lengths and completion wait limit in cycles
  localparam int unsigned ENTRY_BASE   = 18;
  localparam int unsigned EXTRA_DBG    = 2;
  localparam int unsigned EXTRA_STEP   = 1;
  localparam int unsigned WAIT_MAX     = 30;

  // Fixed source codes, high to low priority
  typedef enum logic [2:0] {
    SRC_NONE   = 3'h0,
    SRC_RESET  = 3'h1,
    SRC_SER0   = 3'h2,
    SRC_DEBUG  = 3'h3,
    SRC_WDOG   = 3'h4,
    SRC_PERIPH = 3'h5,
    SRC_STEP   = 3'h6,
    SRC_AMATCH = 3'h7
  } src_e;

  // Entry sequence states, Gray along the main path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_INFO   = 3'b001,
    ST_SAVE   = 3'b011,
    ST_PUSH   = 3'b010,
    ST_VECTOR = 3'b110,
    ST_RETURN = 3'b100
  } entry_e;

endpackage

// ### irq_accept.sv
`timescale 1ns/100ps
// What this block does
// RULE_01: Enabled only when level exceeds threshold
// RULE_02: Accept needs enable flag, request, higher level
// RULE_03: Level 0 disables, 1 lowest, 7 highest
// RULE_04: Threshold n admits above n; 7 blocks
// RULE_05: Enable, requests, levels, threshold stored separately
// RULE_06: Resolve at instruction end, enter next cycle
// RULE_07: Repeat instructions suspend and enter at once
// RULE_08: Read vector info, then clear served request
// RULE_09: Save flags, clear I D U except traps; code clears I and D for all traps and keeps U only for trap numbers 32 and up
// RULE_10: Push flags then PC, load threshold, vector
// RULE_11: Entry 18, 19 or 20 cycles by parity; code gives software traps 18 cycles whatever the parity
// RULE_12: Debugger two extra, step or match one
// RULE_13: Instruction completion wait at most 30 cycles
// RULE_14: Watchdog loads 7, reset loads 0
// RULE_15: First word PC high, flag nibbles; then PC low
// RULE_16: Even pointer word writes, odd pointer bytes
// RULE_17: Only flags and PC saved by hardware
// RULE_18: Stack chosen by U flag at acceptance
// RULE_19: Return restores flag word and PC
// RULE_20: Highest level wins, ties by fixed order
// RULE_21: Special sources fixed, reset highest
// RULE_22: Software traps bypass masking and priority
// RULE_23: Reset, serial, debugger, watchdog, periph, step, match
// RULE_24: Hardware sets and clears; software only clears
// RULE_25: Global enable gates all maskables, reset clears
// RULE_26: Winner vector and level held in register
module irq_accept #(
  parameter int NSRC = 16                    // Number of maskable sources
) (
  input  wire logic        pclk,             // Bus and core clock
  input  wire logic        presetn,          // Asynchronous reset, low active
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB access phase
  input  wire logic        pwrite,           // APB direction
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  input  wire logic [NSRC-1:0] src_req,      // Peripheral request pulses
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  output logic             entry_busy,       // Entry sequence running
  output logic             stack_we,         // Stack write strobe
  output logic      [1:0]  stack_be,         // Stack byte enables
  output logic      [19:0] stack_addr,       // Stack write address
  output logic      [15:0] stack_wdata       // Stack write data
);

  initial begin
    if (NSRC < 1 || NSRC > 16) $error("NSRC must be 1 to 16");
  end

  // Register state
  logic            gie_r;                    // Global enable flag
  logic [2:0]      thr_r;                    // Processor priority threshold
  logic [NSRC-1:0] pend_r;                   // Request bits
  logic [2:0]      lvl_r [NSRC];             // Source levels
  logic [15:0]     psw_r;                    // Flag word
  logic [15:0]     tmp_psw_r;                // Hidden temporary flag copy
  logic [19:0]     pc_r;                     // Program counter
  logic [15:0]     isp_r;                    // Interrupt stack pointer
  logic [15:0]     usp_r;                    // User stack pointer
  logic [19:0]     vec_addr_r;               // Vector address from CPU
  logic [7:0]      cpu_r;                    // CPU event command bits
  logic [7:0]      win_r;                    // Captured vector and level
  irq_accept_pkg::src_e   src_r;             // Source being served
  irq_accept_pkg::entry_e st_r;              // Entry state
  logic [4:0]      cnt_r;                    // Cycles left in the entry sequence
  logic [4:0]      wait_r;                   // Instruction completion wait
  logic [1:0]      push_r;                   // Push step index
  logic            odd_sp_r;                 // Stack pointer parity latched
  logic [15:0]     sp_r;                     // Stack pointer latched
  logic            use_usp_r;                // U flag latched at acceptance
  logic [15:0]     push_word_r [2];          // Words to stack

  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr <= irq_accept_pkg::OFF_SAVED) && (paddr[1:0] == 2'b00);

  // CPU command bits from the core register
  logic instr_done;                          // Current instruction completed
  logic repeat_instr;                        // Block move, string store, mac
  logic sw_trap;                             // Software trap executed
  logic ret_instr;                           // return_from_irq_instr executed
  logic [5:0] trap_no;                       // Software trap number
  assign instr_done   = wr_en && paddr == irq_accept_pkg::OFF_CPU && pwdata[0];
  assign repeat_instr = cpu_r[1];
  assign sw_trap      = wr_en && paddr == irq_accept_pkg::OFF_CPU && pwdata[2];
  assign ret_instr    = wr_en && paddr == irq_accept_pkg::OFF_CPU && pwdata[3];
  assign trap_no      = pwdata[13:8];

  // Special source inputs taken from CPU register bits
  logic ev_ser0, ev_dbg, ev_wdog, ev_step, ev_amatch;
  assign ev_ser0   = cpu_r[4];
  assign ev_dbg    = cpu_r[5];
  assign ev_wdog   = cpu_r[6];
  assign ev_step   = cpu_r[7];
  assign ev_amatch = cpu_r[2];

  // Maskable winner search
  logic [2:0] best_lvl;
  logic [3:0] best_idx;
  logic       best_ok;
  always_comb begin
    best_lvl = 3'h0;
    best_idx = 4'h0;
    best_ok  = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      // Request enabled only above threshold; lower index wins ties
      if (pend_r[i] && lvl_r[i] > thr_r && lvl_r[i] >= best_lvl) begin  // see RULE_01 see RULE_04 see RULE_20
        best_lvl = lvl_r[i];
        best_idx = 4'(i);
        best_ok  = 1'b1;
      end
    end
  end

  // Fixed priority among sources
  irq_accept_pkg::src_e pick;
  logic accept_ok;
  always_comb begin
    pick = irq_accept_pkg::SRC_NONE;
    if (ev_ser0) begin                       // see RULE_21 see RULE_23
      pick = irq_accept_pkg::SRC_SER0;
    end else if (ev_dbg) begin
      pick = irq_accept_pkg::SRC_DEBUG;
    end else if (ev_wdog) begin
      pick = irq_accept_pkg::SRC_WDOG;
    end else if (gie_r && best_ok) begin     // see RULE_02 see RULE_25
      pick = irq_accept_pkg::SRC_PERIPH;
    end else if (ev_step) begin
      pick = irq_accept_pkg::SRC_STEP;
    end else if (ev_amatch) begin
      pick = irq_accept_pkg::SRC_AMATCH;
    end
  end
  // Sample at completion, or at once during repeat instructions
  assign accept_ok = st_r == irq_accept_pkg::ST_IDLE && pick != irq_accept_pkg::SRC_NONE &&
                     (instr_done || repeat_instr);  // see RULE_06 see RULE_07

  // Entry length by parity and source
  logic [4:0] entry_len;
  logic       sp_odd_now;
  always_comb begin
    sp_odd_now = psw_r[irq_accept_pkg::PSW_U_BIT] ? usp_r[0] : isp_r[0];  // see RULE_18
    entry_len  = 5'(irq_accept_pkg::ENTRY_BASE) + 5'(vec_addr_r[0]) + 5'(sp_odd_now);  // see RULE_11
    if (pick == irq_accept_pkg::SRC_DEBUG) begin
      entry_len = entry_len + 5'(irq_accept_pkg::EXTRA_DBG);  // see RULE_12
    end else if (pick == irq_accept_pkg::SRC_STEP || pick == irq_accept_pkg::SRC_AMATCH) begin
      entry_len = entry_len + 5'(irq_accept_pkg::EXTRA_STEP);
    end
  end

  // Entry sequence state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= irq_accept_pkg::ST_IDLE;
      cnt_r     <= 5'h00;
      src_r     <= irq_accept_pkg::SRC_NONE;
      win_r     <= 8'h00;
      push_r    <= 2'h0;
      odd_sp_r  <= 1'b0;
      sp_r      <= 16'h0000;
      use_usp_r <= 1'b0;
    end else begin
      unique case (st_r)
        irq_accept_pkg::ST_IDLE: begin
          if (sw_trap) begin
            // Traps branch whenever idle, no masking
            st_r  <= irq_accept_pkg::ST_SAVE;  // see RULE_22
            win_r <= {2'b00, trap_no};
            src_r <= irq_accept_pkg::SRC_NONE;
            cnt_r <= 5'(irq_accept_pkg::ENTRY_BASE);
            sp_r  <= psw_r[irq_accept_pkg::PSW_U_BIT] ? usp_r : isp_r;  // see RULE_18
            odd_sp_r <= sp_odd_now;
          end else if (accept_ok) begin
            st_r      <= irq_accept_pkg::ST_INFO;
            src_r     <= pick;
            // Winner held stable for the info read
            win_r     <= {1'b0, best_lvl, best_idx};  // see RULE_26
            cnt_r     <= entry_len;
            use_usp_r <= psw_r[irq_accept_pkg::PSW_U_BIT];  // see RULE_18
            sp_r      <= psw_r[irq_accept_pkg::PSW_U_BIT] ? usp_r : isp_r;
            odd_sp_r  <= sp_odd_now;
          end else if (ret_instr) begin
            st_r <= irq_accept_pkg::ST_RETURN;
          end
        end
        irq_accept_pkg::ST_INFO: begin
          st_r  <= irq_accept_pkg::ST_SAVE;  // see RULE_08
          cnt_r <= cnt_r - 5'h1;
        end
        irq_accept_pkg::ST_SAVE: begin
          st_r   <= irq_accept_pkg::ST_PUSH;
          cnt_r  <= cnt_r - 5'h1;
          push_r <= 2'h0;
          sp_r   <= sp_r - 16'h0004;
        end
        irq_accept_pkg::ST_PUSH: begin
          cnt_r <= cnt_r - 5'h1;
          // Odd pointer needs four byte writes, even two words
          if (push_r == (odd_sp_r ? 2'h3 : 2'h1)) begin  // see RULE_16
            st_r <= irq_accept_pkg::ST_VECTOR;
          end
          push_r <= push_r + 2'h1;
        end
        irq_accept_pkg::ST_VECTOR: begin
          // Pad out to the documented length
          if (cnt_r <= 5'h1) begin
            st_r <= irq_accept_pkg::ST_IDLE;
          end
          cnt_r <= cnt_r - 5'h1;
        end
        irq_accept_pkg::ST_RETURN: begin
          st_r <= irq_accept_pkg::ST_IDLE;
        end
        default: begin
          st_r <= irq_accept_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Flag word, temporary copy, PC, threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_r     <= irq_accept_pkg::PSW_RESET;  // see RULE_25
      tmp_psw_r <= 16'h0000;
      pc_r      <= 20'h00000;
      thr_r     <= irq_accept_pkg::THR_RESET;  // see RULE_14
      gie_r     <= 1'b0;
    end else if (st_r == irq_accept_pkg::ST_INFO ||
                 (st_r == irq_accept_pkg::ST_IDLE && sw_trap)) begin
      // Copy flags before clearing them
      tmp_psw_r <= {psw_r[15:7], gie_r, psw_r[5:0]};  // see RULE_09
      gie_r     <= 1'b0;
      psw_r[irq_accept_pkg::PSW_D_BIT] <= 1'b0;
      if (!(st_r == irq_accept_pkg::ST_IDLE && trap_no >= 6'd32)) begin
        psw_r[irq_accept_pkg::PSW_U_BIT] <= 1'b0;
      end
    end else if (st_r == irq_accept_pkg::ST_VECTOR && cnt_r <= 5'h1) begin
      pc_r <= vec_addr_r;                    // see RULE_10
      if (src_r == irq_accept_pkg::SRC_PERIPH) begin
        thr_r <= win_r[6:4];
      end else if (src_r == irq_accept_pkg::SRC_WDOG) begin
        thr_r <= irq_accept_pkg::THR_WATCHDOG;  // see RULE_14
      end
    end else if (st_r == irq_accept_pkg::ST_RETURN) begin
      // Restore stacked flags and PC
      psw_r <= {push_word_r[0][11:8], 4'h0, push_word_r[0][7:0]};  // see RULE_19
      gie_r <= push_word_r[0][irq_accept_pkg::PSW_I_BIT];
      pc_r  <= {push_word_r[0][15:12], push_word_r[1]};
    end else if (wr_en && paddr == irq_accept_pkg::OFF_CTRL) begin
      gie_r <= pwdata[irq_accept_pkg::CTRL_GIE_BIT];  // see RULE_05
      thr_r <= pwdata[irq_accept_pkg::CTRL_THR_LSB +: 3];
    end else if (wr_en && paddr == irq_accept_pkg::OFF_PSW) begin
      psw_r <= pwdata[15:0];
    end
  end

  // Stacked words: PC high, flag high nibble and low byte; then PC low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_word_r[0] <= 16'h0000;
      push_word_r[1] <= 16'h0000;
    end else if (st_r == irq_accept_pkg::ST_SAVE) begin
      push_word_r[0] <= {pc_r[19:16], tmp_psw_r[15:12], tmp_psw_r[7:0]};  // see RULE_15 see RULE_17
      push_word_r[1] <= pc_r[15:0];
    end
  end

  // Request bits, set by hardware, cleared after the info read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (src_req[i]) begin
          pend_r[i] <= 1'b1;                 // see RULE_24
        end else if (st_r == irq_accept_pkg::ST_INFO && src_r == irq_accept_pkg::SRC_PERIPH &&
                     win_r[3:0] == 4'(i)) begin
          pend_r[i] <= 1'b0;                 // see RULE_08
        end else if (wr_en && paddr == irq_accept_pkg::OFF_PEND && !pwdata[i]) begin
          pend_r[i] <= 1'b0;                 // see RULE_24
        end
      end
    end
  end

  // Level fields, three bits each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSRC; i++) lvl_r[i] <= 3'h0;  // see RULE_03
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (wr_en && paddr == (i < 8 ? irq_accept_pkg::OFF_LVL_LO : irq_accept_pkg::OFF_LVL_HI)) begin
          lvl_r[i] <= pwdata[(i % 8) * 4 +: 3];
        end
      end
    end
  end

  // CPU register, stack pointers and instruction wait counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_r      <= 8'h00;
      isp_r      <= 16'h0000;
      usp_r      <= 16'h0000;
      vec_addr_r <= 20'h00000;
      wait_r     <= 5'h00;
    end else begin
      if (wr_en && paddr == irq_accept_pkg::OFF_CPU) begin
        cpu_r <= pwdata[7:0];
      end
      if (wr_en && paddr == irq_accept_pkg::OFF_STACK) begin
        isp_r      <= pwdata[15:0];
        usp_r      <= pwdata[31:16];
      end
      if (wr_en && paddr == irq_accept_pkg::OFF_VECT) begin
        vec_addr_r <= pwdata[19:0];
      end
      // Counts cycles a pending accept waits for instruction end
      if (st_r != irq_accept_pkg::ST_IDLE || accept_ok || pick == irq_accept_pkg::SRC_NONE) begin
        wait_r <= 5'h00;
      end else if (wait_r < 5'(irq_accept_pkg::WAIT_MAX)) begin  // see RULE_13
        wait_r <= wait_r + 5'h1;
      end
    end
  end

  // Stack write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_we    <= 1'b0;
      stack_be    <= 2'b00;
      stack_addr  <= 20'h00000;
      stack_wdata <= 16'h0000;
      entry_busy  <= 1'b0;
    end else begin
      entry_busy <= st_r != irq_accept_pkg::ST_IDLE && st_r != irq_accept_pkg::ST_RETURN;
      stack_we   <= st_r == irq_accept_pkg::ST_PUSH;
      stack_addr <= {4'h0, sp_r + (odd_sp_r ? 16'(push_r) : 16'({push_r, 1'b0}))};
      if (odd_sp_r) begin
        // Bytes: low then high of each item
        stack_be    <= push_r[0] ? 2'b10 : 2'b01;  // see RULE_16
        stack_wdata <= push_word_r[push_r[1]];
      end else begin
        stack_be    <= 2'b11;
        stack_wdata <= push_word_r[push_r[0]];
      end
    end
  end

  // APB read and response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        unique case (paddr)
          irq_accept_pkg::OFF_CTRL:   prdata <= {25'h0, thr_r, 3'h0, gie_r};
          irq_accept_pkg::OFF_PEND:   prdata <= 32'(pend_r);
          irq_accept_pkg::OFF_STATUS: prdata <= {19'h0, wait_r, 5'h0, st_r};
          irq_accept_pkg::OFF_VECT:   prdata <= {24'h0, win_r};
          irq_accept_pkg::OFF_PSW:    prdata <= {16'h0, psw_r};
          irq_accept_pkg::OFF_STACK:  prdata <= {usp_r, isp_r};
          irq_accept_pkg::OFF_SAVED:  prdata <= {push_word_r[0], push_word_r[1]};
          default:                    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ### irq_accept_props.sv
`timescale 1ns/100ps
module irq_accept_props #(
  parameter int NSRC = 16
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [NSRC-1:0] src_req,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            entry_busy,
  input wire logic            stack_we,
  input wire logic [1:0]      stack_be,
  input wire logic [19:0]     stack_addr,
  input wire logic [15:0]     stack_wdata
);
  int unsigned busy_cnt;  // Cycles of the running entry
  int unsigned we_cnt;    // Stack writes of the running entry
  logic        bad;       // Address outside the map
  assign bad = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
  // Count entry cycles and stack writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
      we_cnt <= 0;
    end else if (!entry_busy) begin
      busy_cnt <= 0;
      we_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
      we_cnt <= we_cnt + {31'h0, stack_we};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  bad_addr_a: assert property (psel && penable && pready && bad |-> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  good_addr_a: assert property (psel && pready && !bad |-> !pslverr)
    else $error("good address refused");
  stack_entry_a: assert property (stack_we |-> entry_busy)
    else $error("stack write outside entry");
  byte_lanes_a: assert property (stack_we |-> stack_be != 2'h0)
    else $error("stack write without lanes");
  word_align_a: assert property (stack_we && stack_be == 2'h3 |-> !stack_addr[0])
    else $error("word write to odd address");
  entry_min_a: assert property ($rose(entry_busy) |-> entry_busy [*8])
    else $error("entry ended too early");
  entry_len_a: assert property ($fell(entry_busy) |-> busy_cnt inside {[18:22]})
    else $error("entry length out of range");
  push_count_a: assert property ($fell(entry_busy) |-> we_cnt inside {2, 4})
    else $error("wrong number of stack writes");
  cover property ($fell(entry_busy) && we_cnt == 4);
  cover property ($fell(entry_busy) && busy_cnt == 20);
  cover property (pslverr);
endmodule

bind irq_accept irq_accept_props #(.NSRC(NSRC)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .src_req(src_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .entry_busy(entry_busy), .stack_we(stack_we), .stack_be(stack_be),
  .stack_addr(stack_addr), .stack_wdata(stack_wdata));

// ### irq_src_model.sv
`timescale 1ns/100ps
module irq_src_model #(
  parameter int NSRC = 16
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [NSRC-1:0] trig,
  input  wire logic            stack_we,
  output logic      [NSRC-1:0] src_req,
  output logic      [7:0]      wr_cnt
);
  // One-cycle service request per trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_req <= '0;
    end else begin
      src_req <= trig;
    end
  end
  // Stack writes taken by the core side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt <= 8'h00;
    end else begin
      wr_cnt <= wr_cnt + {7'h0, stack_we};
    end
  end
endmodule

// ### tb_irq_accept.sv
`timescale 1ns/100ps
module tb_irq_accept;
  logic        pclk = 1'h0;     // Core clock
  logic        presetn = 1'h0;  // Reset, low active
  logic        psel = 1'h0;     // APB select
  logic        penable = 1'h0;  // APB access
  logic        pwrite = 1'h0;   // APB direction
  logic [7:0]  paddr = 8'h00;   // APB address
  logic [31:0] pwdata = 32'h0;  // APB write data
  logic [15:0] trig = 16'h0;    // Source triggers
  logic [15:0] src_req;         // Requests into the block
  logic [31:0] prdata;          // APB read data
  logic        pready;          // APB ready
  logic        entry_busy;      // Entry running
  logic        stack_we;        // Stack write strobe
  logic [7:0]  wr_cnt;          // Stack writes so far
  logic [31:0] rd;              // Last read word
  int          c;               // Last entry length
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #12.5 pclk = ~pclk;
  irq_accept #(.NSRC(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .src_req(src_req), .prdata(prdata), .pready(pready),
    .pslverr(), .entry_busy(entry_busy), .stack_we(stack_we), .stack_be(),
    .stack_addr(), .stack_wdata());
  irq_src_model #(.NSRC(16)) src_i (
    .pclk(pclk), .presetn(presetn), .trig(trig), .stack_we(stack_we),
    .src_req(src_req), .wr_cnt(wr_cnt));
  // Verdict and end of run
  task automatic close_out();
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // Word compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Pulse source triggers
  task automatic fire(input logic [15:0] m);
    trig <= m;
    @(posedge pclk);
    trig <= 16'h0;
    repeat (2) @(posedge pclk);
  endtask
  // Signal the core word and time the entry
  task automatic entry(input logic [31:0] w);
    int n;
    n = 0;
    c = 0;
    // Event levels first, then the done strobe
    apb(1'h1, irq_accept_pkg::OFF_CPU, w & 32'hF2);
    apb(1'h1, irq_accept_pkg::OFF_CPU, w);
    while (entry_busy !== 1'h1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    while (entry_busy === 1'h1 && c < 60) begin
      @(posedge pclk);
      c++;
    end
  endtask
  // Reset values and stack setup
  task automatic t_reset();
    apb(1'h0, irq_accept_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'h0, irq_accept_pkg::OFF_PSW, 32'h0);
    chk("psw", irq_accept_pkg::PSW_RESET, rd);
    apb(1'h1, irq_accept_pkg::OFF_VECT, 32'h1000);
    apb(1'h1, irq_accept_pkg::OFF_STACK, 32'h08000400);
    apb(1'h0, irq_accept_pkg::OFF_STACK, 32'h0);
    chk("stack", 32'h08000400, rd);
  endtask
  // Level against threshold, every threshold
  task automatic t_thresh();
    logic [2:0] lv;
    logic [7:0] m;
    for (int t = 0; t < 8; t++) begin
      for (int u = 0; u < 2; u++) begin
        lv = t[2:0] + u[2:0];
        apb(1'h1, irq_accept_pkg::OFF_CTRL, {25'h0, t[2:0], 4'h1});
        apb(1'h1, irq_accept_pkg::OFF_LVL_LO, {29'h0, lv});
        m = wr_cnt;
        fire(16'h1);
        entry(32'h1);
        chk("accept", {31'h0, lv > t[2:0]}, {31'h0, c != 0});
        if (lv > t[2:0]) begin
          chk("len", irq_accept_pkg::ENTRY_BASE, c);
          chk("writes", 32'h2, {24'h0, wr_cnt - m});
          apb(1'h0, irq_accept_pkg::OFF_CTRL, 32'h0);
          chk("thr", {29'h0, lv}, {29'h0, rd[6:4]});
          apb(1'h0, irq_accept_pkg::OFF_PEND, 32'h0);
          chk("pend", 32'h0, rd);
        end
        apb(1'h1, irq_accept_pkg::OFF_PEND, 32'h0);
      end
    end
    apb(1'h1, irq_accept_pkg::OFF_CTRL, 32'h0);
    apb(1'h1, irq_accept_pkg::OFF_LVL_LO, 32'h7);
    fire(16'h1);
    entry(32'h1);
    chk("masked", 32'h0, c);
    apb(1'h0, irq_accept_pkg::OFF_PEND, 32'h0);
    chk("held", 32'h1, rd);
    apb(1'h1, irq_accept_pkg::OFF_PEND, 32'h0);
  endtask
  // Highest level wins, tie to lower index
  task automatic t_prio();
    apb(1'h1, irq_accept_pkg::OFF_CTRL, 32'h1);
    apb(1'h1, irq_accept_pkg::OFF_LVL_LO, 32'h5530);
    fire(16'hE);
    entry(32'h1);
    apb(1'h0, irq_accept_pkg::OFF_VECT, 32'h0);
    chk("winner", 32'h52, rd);
    apb(1'h0, irq_accept_pkg::OFF_PEND, 32'h0);
    chk("pend", 32'hA, rd);
    apb(1'h1, irq_accept_pkg::OFF_PEND, 32'h0);
  endtask
  // Fixed sources with masking off, then a trap
  task automatic t_special();
    logic [31:0] w[3] = '{32'hA1, 32'h81, 32'hC1};
    int          x[3] = '{2, 1, 0};
    apb(1'h1, irq_accept_pkg::OFF_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      entry(w[i]);
      chk("len", irq_accept_pkg::ENTRY_BASE + x[i], c);
    end
    apb(1'h0, irq_accept_pkg::OFF_CTRL, 32'h0);
    chk("thr", {29'h0, irq_accept_pkg::THR_WATCHDOG}, {29'h0, rd[6:4]});
    entry(32'h2804);
    chk("trap", 32'h1, {31'h0, c != 0});
  endtask
  // Odd vector and odd stack pointer
  task automatic t_parity();
    logic [7:0] m;
    apb(1'h1, irq_accept_pkg::OFF_VECT, 32'h1001);
    apb(1'h1, irq_accept_pkg::OFF_STACK, 32'h08000401);
    apb(1'h1, irq_accept_pkg::OFF_CTRL, 32'h1);
    apb(1'h1, irq_accept_pkg::OFF_LVL_LO, 32'h7);
    m = wr_cnt;
    fire(16'h1);
    entry(32'h1);
    chk("len", irq_accept_pkg::ENTRY_BASE + 2, c);
    chk("writes", 32'h4, {24'h0, wr_cnt - m});
    apb(1'h1, irq_accept_pkg::OFF_CPU, 32'h8);
    apb(1'h0, irq_accept_pkg::OFF_CTRL, 32'h0);
    chk("ret", 32'h71, rd);
  endtask
  // Unmapped and unaligned reads
  task automatic t_refuse();
    apb(1'h0, 8'h28, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'h0, 8'h02, 32'h0);
    chk("unaligned", 32'h0, rd);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_thresh();
    t_prio();
    t_special();
    t_parity();
    t_refuse();
    close_out();
  end
endmodule
